// ---- design/bit_manip_pkg.sv ----
// constants and operation codes for the single-bit manipulation unit
// Operation
// - set op writes 1, other bits kept
// - clear op writes 0, other bits kept
// - invert op complements bit, writes byte back
// - test op puts inverted bit into zero
// - set/clear/invert/test: immediate or register position
// - carry ops take immediate bit position only
// - carry becomes carry AND bit
// - carry becomes carry AND inverted bit
// - carry becomes carry OR bit
// - carry becomes carry OR inverted bit
// - carry becomes carry XOR bit
// - carry becomes carry XOR inverted bit
// - bit load copies bit into carry
// - inverted load copies inverted bit to carry
// - bit store writes carry into bit
// - inverted store writes inverted carry into bit
// - carry is the flags register carry bit
`default_nettype none
package bit_manip_pkg;
    // operation selector driven by the instruction decoder
    typedef enum logic [3:0] {
        bit_set_op,
        bit_clear_op,
        bit_invert_op,
        bit_test_op,
        carry_and_bit_op,
        carry_and_inverted_bit_op,
        carry_or_bit_op,
        carry_or_inverted_bit_op,
        carry_xor_bit_op,
        carry_xor_inverted_bit_op,
        bit_to_carry_load_op,
        inverted_bit_to_carry_op,
        carry_to_bit_store_op,
        inverted_carry_to_bit_op
    } op_type;

    // field positions inside the condition flags register
    localparam logic [2:0] CARRY_POS = 3'h0;
    localparam logic [2:0] ZERO_POS = 3'h2;
    // reset values of the output registers
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // one-hot seed used to build bit masks
    localparam logic [7:0] BIT_ONE = 8'h01;
endpackage
`default_nettype wire

// ---- design/bit_lane_select.sv ----
// picks one bit of a byte and builds the byte with that bit replaced
`default_nettype none
module bit_lane_select (
    // operand and position
    input wire logic [7:0] byte_in,
    input wire logic [2:0] pos,
    // value that replaces the chosen bit
    input wire logic new_bit,
    // results
    output logic picked_bit,
    output logic [7:0] byte_out
);
    // chosen bit, straight mux
    assign picked_bit = byte_in[pos];

    // every lane keeps its own bit unless it is the chosen one
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_lane
            assign byte_out[i] = (pos == 3'(i)) ? new_bit : byte_in[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- design/bit_manipulation_unit.sv ----
// single-bit manipulation datapath: bit modify, bit test and carry logic
`default_nettype none
module bit_manipulation_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // request from the instruction decoder
    input wire logic op_valid,
    input wire bit_manip_pkg::op_type op_code,
    input wire logic op_in_mem,
    // operand byte from register file or memory read
    input wire logic [7:0] op_byte,
    // bit position sources
    input wire logic [2:0] bit_imm,
    input wire logic [7:0] bit_reg,
    input wire logic bit_from_reg,
    // current condition flags register
    input wire logic [7:0] flags_in,
    // completion
    output logic op_done,
    output logic op_refused,
    // operand write-back
    output logic [7:0] byte_out,
    output logic byte_write,
    output logic byte_to_mem,
    // condition flags write-back
    output logic [7:0] flags_out,
    output logic flags_write
);
    // resolved bit position
    logic [2:0] pos;
    // operand bit at that position
    logic sel_bit;
    // value to place in the operand bit for modifying ops
    logic put_bit;
    // operand with the chosen bit replaced
    logic [7:0] mod_byte;
    // class of the current op
    logic is_modify;
    logic reg_pos_allowed;
    // request refused or accepted this cycle
    logic refuse;
    logic accept;
    // next flags value and which flags ops touch
    logic [7:0] next_flags;
    logic is_flag_op;
    // current carry taken from the flags register
    logic carry;

    assign carry = flags_in[bit_manip_pkg::CARRY_POS];

    // register or immediate position
    // only the low three bits of the register count; upper bits are ignored
    assign pos = bit_from_reg ? bit_reg[2:0] : bit_imm;

    // ops that may name the bit from a register
    always_comb begin
        reg_pos_allowed = 1'b0;
        case (op_code)
            bit_manip_pkg::bit_set_op: reg_pos_allowed = 1'b1;
            bit_manip_pkg::bit_clear_op: reg_pos_allowed = 1'b1;
            bit_manip_pkg::bit_invert_op: reg_pos_allowed = 1'b1;
            bit_manip_pkg::bit_test_op: reg_pos_allowed = 1'b1;
            default: reg_pos_allowed = 1'b0;
        endcase
    end

    // carry ops refuse register positions
    // a refused op changes nothing, so the decoder sees the fault without side effects
    assign refuse = op_valid && bit_from_reg && !reg_pos_allowed;
    assign accept = op_valid && !refuse;

    // new operand bit for each modifying op
    always_comb begin
        is_modify = 1'b1;
        put_bit = sel_bit;
        case (op_code)
            bit_manip_pkg::bit_set_op: put_bit = 1'b1;
            bit_manip_pkg::bit_clear_op: put_bit = 1'b0;
            bit_manip_pkg::bit_invert_op: put_bit = ~sel_bit;
            bit_manip_pkg::carry_to_bit_store_op: put_bit = carry;
            bit_manip_pkg::inverted_carry_to_bit_op: put_bit = ~carry;
            // everything else leaves the byte as read
            default: begin
                is_modify = 1'b0;
                put_bit = sel_bit;
            end
        endcase
    end

    // bit pick and replace on the operand byte
    bit_lane_select u_lane (
        .byte_in(op_byte),
        .pos(pos),
        .new_bit(put_bit),
        .picked_bit(sel_bit),
        .byte_out(mod_byte)
    );

    // flag result; only the one targeted flag ever moves
    always_comb begin
        next_flags = flags_in;
        is_flag_op = 1'b1;
        case (op_code)
            bit_manip_pkg::bit_test_op: next_flags[bit_manip_pkg::ZERO_POS] = ~sel_bit;
            bit_manip_pkg::carry_and_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry & sel_bit;
            bit_manip_pkg::carry_and_inverted_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry & ~sel_bit;
            bit_manip_pkg::carry_or_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry | sel_bit;
            bit_manip_pkg::carry_or_inverted_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry | ~sel_bit;
            bit_manip_pkg::carry_xor_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry ^ sel_bit;
            bit_manip_pkg::carry_xor_inverted_bit_op: next_flags[bit_manip_pkg::CARRY_POS] = carry ^ ~sel_bit;
            bit_manip_pkg::bit_to_carry_load_op: next_flags[bit_manip_pkg::CARRY_POS] = sel_bit;
            bit_manip_pkg::inverted_bit_to_carry_op: next_flags[bit_manip_pkg::CARRY_POS] = ~sel_bit;
            // modifying ops leave the flags alone
            default: is_flag_op = 1'b0;
        endcase
    end

    // operand write-back register
    // whole byte written back
    // the full byte goes back even to memory; other bits are the ones just read,
    // so a bit changed by another master between read and write would be lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            byte_out <= bit_manip_pkg::BYTE_RESET;
            byte_write <= 1'b0;
            byte_to_mem <= 1'b0;
        end else begin
            byte_write <= accept && is_modify;
            byte_to_mem <= accept && is_modify && op_in_mem;
            if (accept) begin
                byte_out <= is_modify ? mod_byte : op_byte;
            end
        end
    end

    // flags write-back register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags_out <= bit_manip_pkg::FLAGS_RESET;
            flags_write <= 1'b0;
        end else begin
            flags_write <= accept && is_flag_op;
            if (accept) begin
                flags_out <= next_flags;
            end
        end
    end

    // completion strobes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            op_done <= 1'b0;
            op_refused <= 1'b0;
        end else begin
            op_done <= accept;
            op_refused <= refuse;
        end
    end

    // checks on the datapath

    set_bit_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::bit_set_op) |=>
        byte_write && byte_out == ($past(op_byte) | (bit_manip_pkg::BIT_ONE << $past(pos))))
        else $error("set did not write one into chosen bit");

    clear_bit_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::bit_clear_op) |=>
        byte_write && byte_out == ($past(op_byte) & ~(bit_manip_pkg::BIT_ONE << $past(pos))))
        else $error("clear did not write zero into chosen bit");

    invert_bit_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::bit_invert_op) |=>
        byte_write && byte_out == ($past(op_byte) ^ (bit_manip_pkg::BIT_ONE << $past(pos))))
        else $error("invert did not complement chosen bit");

    test_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::bit_test_op) |=>
        flags_write && flags_out[bit_manip_pkg::ZERO_POS] == ~$past(sel_bit))
        else $error("test put wrong value in zero flag");

    reg_refuse_a: assert property (@(posedge sys_clk) disable iff (srst)
        (op_valid && bit_from_reg && op_code == bit_manip_pkg::carry_or_bit_op) |=>
        op_refused && !op_done && !byte_write && !flags_write)
        else $error("carry op with register position not refused");

    carry_and_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::carry_and_bit_op) |=>
        flags_out[bit_manip_pkg::CARRY_POS] == ($past(carry) & $past(sel_bit)))
        else $error("carry and result wrong");

    carry_xor_inv_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::carry_xor_inverted_bit_op) |=>
        flags_out[bit_manip_pkg::CARRY_POS] == ($past(carry) ^ ~$past(sel_bit)))
        else $error("carry xor inverse result wrong");

    load_inv_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::inverted_bit_to_carry_op) |=>
        flags_write && flags_out[bit_manip_pkg::CARRY_POS] == ~$past(sel_bit))
        else $error("inverted load put wrong carry");

    store_inv_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && op_code == bit_manip_pkg::inverted_carry_to_bit_op) |=>
        byte_write && byte_out[$past(pos)] == ~$past(carry) && !flags_write)
        else $error("inverted store wrote wrong bit");

    // the strobe may only stay up when a second memory op follows back to back
    mem_writeback_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && is_modify && op_in_mem) |=> byte_to_mem && byte_write
        ##1 (byte_to_mem == $past(accept && is_modify && op_in_mem)))
        else $error("memory operand not written back once");

    flag_only_a: assert property (@(posedge sys_clk) disable iff (srst)
        (accept && is_flag_op) |=>
        !byte_write && ((flags_out ^ $past(flags_in)) & ~((bit_manip_pkg::BIT_ONE << bit_manip_pkg::CARRY_POS)
        | (bit_manip_pkg::BIT_ONE << bit_manip_pkg::ZERO_POS))) == 8'h00)
        else $error("flag op disturbed byte or other flags");
endmodule
`default_nettype wire

// ---- bench/operand_store.sv ----
// behavioural model of the register file byte and flags register feeding the unit
`default_nettype none
module operand_store (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // bench preload of the operand place and flags
    input wire logic load,
    input wire logic [7:0] load_byte,
    input wire logic [7:0] load_flags,
    // write-back from the unit
    input wire logic [7:0] byte_out,
    input wire logic byte_write,
    input wire logic [7:0] flags_out,
    input wire logic flags_write,
    // values presented to the unit
    output logic [7:0] op_byte,
    output logic [7:0] flags_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // operand place: only a write strobe or the bench preload may change it, so stray writes show up
    // whole byte stored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            op_byte <= 8'h00;
        end else if (load) begin
            op_byte <= load_byte;
        end else if (byte_write) begin
            op_byte <= byte_out;
        end
    end

    // flags register: carry shared with every other instruction class
    // single carry holder
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags_in <= 8'h00;
        end else if (load) begin
            flags_in <= load_flags;
        end else if (flags_write) begin
            flags_in <= flags_out;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the single-bit manipulation unit
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // one table row: op, operand, position, flags, expected byte and flags
    typedef struct packed {
        bit_manip_pkg::op_type op;
        logic [7:0] opnd;
        logic [2:0] pos;
        logic [7:0] flg;
        logic [7:0] xbyte;
        logic [7:0] xflg;
    } row_type;
    // stimulus, all defined at time zero
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic op_valid = 1'b0;
    bit_manip_pkg::op_type op_code = bit_manip_pkg::bit_set_op;
    logic op_in_mem = 1'b0;
    logic [2:0] bit_imm = 3'h0;
    logic [7:0] bit_reg = 8'h00;
    logic bit_from_reg = 1'b0;
    logic load = 1'b0;
    logic [7:0] load_byte = 8'h00;
    logic [7:0] load_flags = 8'h00;
    // observed values
    logic [7:0] op_byte, flags_in, byte_out, flags_out;
    logic op_done, op_refused, byte_write, byte_to_mem, flags_write;
    int bad_count = 0;
    int compares = 0;
    row_type rows [16];

    bit_manipulation_unit u_dut (.sys_clk(sys_clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
        .op_in_mem(op_in_mem), .op_byte(op_byte), .bit_imm(bit_imm), .bit_reg(bit_reg),
        .bit_from_reg(bit_from_reg), .flags_in(flags_in), .op_done(op_done), .op_refused(op_refused),
        .byte_out(byte_out), .byte_write(byte_write), .byte_to_mem(byte_to_mem), .flags_out(flags_out),
        .flags_write(flags_write));
    operand_store u_store (.sys_clk(sys_clk), .srst(srst), .load(load), .load_byte(load_byte),
        .load_flags(load_flags), .byte_out(byte_out), .byte_write(byte_write), .flags_out(flags_out),
        .flags_write(flags_write), .op_byte(op_byte), .flags_in(flags_in));

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // all five strobes one cycle after the request
    task automatic strobes(input logic done, input logic refd, input logic bw, input logic mem, input logic fw);
        chk1("op_done", done, op_done);
        chk1("op_refused", refd, op_refused);
        chk1("byte_write", bw, byte_write);
        chk1("byte_to_mem", mem, byte_to_mem);
        chk1("flags_write", fw, flags_write);
    endtask

    task automatic preload(input logic [7:0] b, input logic [7:0] f);
        load = 1'b1;
        load_byte = b;
        load_flags = f;
        @(negedge sys_clk);
        load = 1'b0;
    endtask

    // the unused position source carries the inverse so a wrong pick shows
    task automatic issue(input bit_manip_pkg::op_type op, input logic [2:0] pos, input logic rs, input logic mem,
                         input logic hold);
        op_valid = 1'b1;
        op_code = op;
        op_in_mem = mem;
        bit_from_reg = rs;
        bit_imm = rs ? ~pos : pos;
        bit_reg = {5'h15, rs ? pos : ~pos};
        @(negedge sys_clk);
        if (!hold) op_valid = 1'b0;
    endtask

    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 75 cycles
    initial begin
        #16000;
        bad_count++;
        conclude();
    end

    initial begin
        logic md;
        rows = '{
            '{bit_manip_pkg::bit_set_op, 8'hA5, 3'h1, 8'h5A, 8'hA7, 8'h5A},
            '{bit_manip_pkg::bit_clear_op, 8'hA5, 3'h7, 8'h5A, 8'h25, 8'h5A},
            '{bit_manip_pkg::bit_invert_op, 8'hA5, 3'h0, 8'h5A, 8'hA4, 8'h5A},
            '{bit_manip_pkg::bit_invert_op, 8'h00, 3'h6, 8'h00, 8'h40, 8'h00},
            '{bit_manip_pkg::bit_test_op, 8'h10, 3'h4, 8'hFF, 8'h10, 8'hFB},
            '{bit_manip_pkg::bit_test_op, 8'h10, 3'h3, 8'h00, 8'h10, 8'h04},
            '{bit_manip_pkg::carry_and_bit_op, 8'h80, 3'h7, 8'hFF, 8'h80, 8'hFF},
            '{bit_manip_pkg::carry_and_inverted_bit_op, 8'h80, 3'h7, 8'hFF, 8'h80, 8'hFE},
            '{bit_manip_pkg::carry_or_bit_op, 8'h00, 3'h2, 8'hF0, 8'h00, 8'hF0},
            '{bit_manip_pkg::carry_or_inverted_bit_op, 8'h00, 3'h2, 8'hF0, 8'h00, 8'hF1},
            '{bit_manip_pkg::carry_xor_bit_op, 8'h08, 3'h3, 8'h01, 8'h08, 8'h00},
            '{bit_manip_pkg::carry_xor_inverted_bit_op, 8'h00, 3'h3, 8'h01, 8'h00, 8'h00},
            '{bit_manip_pkg::bit_to_carry_load_op, 8'h40, 3'h6, 8'h00, 8'h40, 8'h01},
            '{bit_manip_pkg::inverted_bit_to_carry_op, 8'h40, 3'h6, 8'hFF, 8'h40, 8'hFE},
            '{bit_manip_pkg::carry_to_bit_store_op, 8'h00, 3'h5, 8'h01, 8'h20, 8'h01},
            '{bit_manip_pkg::inverted_carry_to_bit_op, 8'hFF, 3'h5, 8'h01, 8'hDF, 8'h01}};
        repeat (8) @(negedge sys_clk);
        chk8("byte_out at reset", 8'h00, byte_out);
        chk8("flags_out at reset", 8'h00, flags_out);
        srst = 1'b0;
        // table: odd rows of the position ops take the register source
        for (int i = 0; i < 16; i++) begin
            md = (rows[i].op <= bit_manip_pkg::bit_invert_op) || (rows[i].op >= bit_manip_pkg::carry_to_bit_store_op);
            preload(rows[i].opnd, rows[i].flg);
            issue(rows[i].op, rows[i].pos, i[0] && (rows[i].op <= bit_manip_pkg::bit_test_op), i[1], 1'b0);
            chk8("byte_out", rows[i].xbyte, byte_out);
            chk8("flags_out", rows[i].xflg, flags_out);
            strobes(1'b1, 1'b0, md, md & i[1], !md);
            @(negedge sys_clk);
            chk8("stored byte", rows[i].xbyte, op_byte);
            chk8("stored flags", rows[i].xflg, flags_in);
        end
        // carry ops with a register position, back to back, all refused
        preload(8'h3C, 8'h01);
        for (int k = 4; k < 14; k++) begin
            issue(bit_manip_pkg::op_type'(k), 3'h2, 1'b1, 1'b1, k < 13);
            strobes(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            chk8("byte_out held", 8'hDF, byte_out);
        end
        // two modifying ops on consecutive cycles
        preload(8'h00, 8'h00);
        issue(bit_manip_pkg::bit_set_op, 3'h0, 1'b0, 1'b1, 1'b1);
        chk8("first byte", 8'h01, byte_out);
        strobes(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        issue(bit_manip_pkg::bit_invert_op, 3'h7, 1'b1, 1'b0, 1'b0);
        chk8("second byte", 8'h80, byte_out);
        strobes(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        // second reset in mid-run clears the outputs
        srst = 1'b1;
        @(negedge sys_clk);
        chk8("byte_out after reset", 8'h00, byte_out);
        chk8("flags_out after reset", 8'h00, flags_out);
        strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        srst = 1'b0;
        // first request in the very first cycle after release, on the cleared store
        issue(bit_manip_pkg::bit_test_op, 3'h0, 1'b0, 1'b0, 1'b0);
        chk8("flags_out after release", 8'h04, flags_out);
        strobes(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        @(negedge sys_clk);
        conclude();
    end
endmodule
`default_nettype wire
